// ---- core/kranpt_regs.sv ----
// Register block for next pages, partner pages and training control
`timescale 1ns/100ps
// Function
// - With next-page control set, the tx page carries message page, ACK2 and toggle from the user low register, NP and ACK from the tx engine.
// - With next-page control set, the user high word fills tx page bits 47 to 16.
// - Page bit 49 comes from the tx engine, never from the user registers.
// - The partner base page low half is captured read-only with its documented fields.
// - The partner base page high word holds technology in 29:5, nonce in 4:0, zero above.
// - The partner next page is stored read-only, low flags and high bits 47 to 16.
// - The partner's 25-bit technology ability is reported; only A0 to A5 are local.
// - Partner FEC bits from D46:D47 show in bits 26:25.
// - Partner remote fault from D13 shows in bit 27.
// - Partner pause from D11:D10 shows in bits 30:28, C2 reads zero.
// - Training control bit 0 enables start-up training, reset value 1.
// - Training control bit 1 disables the training timeout timer, reset value 0.
// - Field 7:4 sets main-tap steps, range 1 to 15, reset 1.
// - Field 11:8 sets pre/post-tap steps, reset 1.
// - Ability overrides apply only while override enable bit 5 of negotiation control is set.
module kranpt_regs
  import kranpt_pkg::*;
(
  input  wire logic              mclk,          // Register clock
  input  wire logic              nrst,          // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr,          // Word address
  input  wire logic [31:0]       wdata,         // Write data
  input  wire logic              wr,            // Write strobe
  input  wire logic              rd,            // Read strobe
  output logic      [31:0]       rdata,         // Read data, cycle after rd
  input  wire logic              np_ctrl,       // Next-page control from negotiation
  input  wire logic              tx_np,         // NP flag from tx engine
  input  wire logic              tx_ack,        // ACK flag from tx engine
  input  wire logic              tx_prbs,       // Pseudo-random bit from tx engine
  output logic      [PG_W-1:0]   tx_np_page,    // Next page to transmit
  input  wire logic [PG_W-1:0]   rx_page,       // Page from rx engine
  input  wire logic              rx_base_acc,   // Base page accepted pulse
  input  wire logic              rx_next_acc,   // Next page accepted pulse
  input  wire logic [5:0]        loc_tech,      // Local technology ability
  input  wire logic [1:0]        loc_fec,       // Local FEC ability
  input  wire logic [2:0]        loc_pause,     // Local pause ability
  output logic      [5:0]        adv_tech,      // Advertised technology
  output logic      [1:0]        adv_fec,       // Advertised FEC
  output logic      [2:0]        adv_pause,     // Advertised pause
  output logic                   train_en,      // Start-up training enable
  output logic                   tmr_dis,       // Training timeout disable
  output logic      [3:0]        main_steps,    // Steps per main-tap update
  output logic      [3:0]        prepost_steps  // Steps per pre/post-tap update
);
  logic [15:0] unp_low_q;
  logic [31:0] unp_high_q;
  logic [15:0] pbp_low_q;
  logic [31:0] pbp_high_q;
  logic [15:0] pnp_low_q;
  logic [31:0] pnp_high_q;
  logic [31:0] trn_q;
  logic [31:0] an_ctrl_q;
  logic [31:0] ovr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] trn_wr;
  logic [3:0]  main_wr;
  logic [3:0]  pp_wr;
  logic [2:0]  p_pause;
  logic        p_rf;
  logic [1:0]  p_fec;
  logic [1:0]  fec_q;
  logic [31:0] adv_word;
  logic [24:0] p_tech;

  wire hit_unp_low  = wr && (addr == OFF_UNP_LOW);
  wire hit_unp_high = wr && (addr == OFF_UNP_HIGH);
  wire hit_trn      = wr && (addr == OFF_TRN_CTRL);
  wire hit_an       = wr && (addr == OFF_AN_CTRL);
  wire hit_ovr      = wr && (addr == OFF_OVR);

  // Zero step counts would stall training, so clamp to the minimum
  assign main_wr = (wdata[TC_MAIN_LO+:4] == 4'h0) ? STEP_MIN : wdata[TC_MAIN_LO+:4];
  assign pp_wr   = (wdata[TC_PP_LO+:4] == 4'h0) ? STEP_MIN : wdata[TC_PP_LO+:4];
  assign trn_wr  = {wdata[31:12] & TC_WMASK[31:12], pp_wr, main_wr,
                    wdata[3:0] & TC_WMASK[3:0]};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unp_low_q  <= 16'h0000;
      unp_high_q <= 32'h0000_0000;
      trn_q      <= TC_RESET;
      an_ctrl_q  <= 32'h0000_0000;
      ovr_q      <= 32'h0000_0000;
    end else begin
      if (hit_unp_low) begin
        unp_low_q <= wdata[15:0] & NP_LOW_WMASK;
      end
      if (hit_unp_high) begin
        unp_high_q <= wdata;
      end
      if (hit_trn) begin
        trn_q <= trn_wr;
      end
      if (hit_an) begin
        an_ctrl_q <= wdata;
      end
      if (hit_ovr) begin
        ovr_q <= wdata & OVR_WMASK;
      end
    end
  end

  // Partner pages: captured only on an accepted page
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pbp_low_q  <= 16'h0000;
      pbp_high_q <= 32'h0000_0000;
      pnp_low_q  <= 16'h0000;
      pnp_high_q <= 32'h0000_0000;
      fec_q      <= 2'b00;
    end else begin
      if (rx_base_acc) begin
        pbp_low_q  <= rx_page[15:0];
        pbp_high_q <= {2'b00, rx_page[45:PG_HI_LO]};
        // FEC sits above the high word, so it is kept beside it
        fec_q      <= rx_page[PG_FEC_LO+1:PG_FEC_LO];
      end
      if (rx_next_acc) begin
        pnp_low_q  <= {rx_page[PG_NP:PG_TOG], 11'h000};
        pnp_high_q <= rx_page[47:PG_HI_LO];
      end
    end
  end

  // Tx next page; bit 49 from the engine, bits 10:0 and 48 unused
  assign tx_np_page = np_ctrl ? {tx_prbs, 1'b0, unp_high_q, tx_np, tx_ack,
                                 unp_low_q[PG_MP:PG_TOG], 11'h000}
                              : {tx_prbs, {(PG_W-1){1'b0}}};

  // Advertised partner abilities decoded from the captured base page
  assign p_tech   = pbp_high_q[29:5];
  assign p_rf     = pbp_low_q[PG_RF];
  // Reserved pause bit C2 reads zero whatever the partner sends
  assign p_pause  = {1'b0, pbp_low_q[PG_PAUSE_LO+1], pbp_low_q[PG_PAUSE_LO]};
  assign p_fec    = fec_q;
  assign adv_word = {1'b0, p_pause, p_rf, p_fec, p_tech};

  // Overrides gated by the negotiation control enable
  wire ovr_on = an_ctrl_q[AN_OVR_EN];
  assign adv_tech  = ovr_on ? ovr_q[OVR_TECH_LO+:6]  : loc_tech;
  assign adv_fec   = ovr_on ? ovr_q[OVR_FEC_LO+:2]   : loc_fec;
  assign adv_pause = ovr_on ? ovr_q[OVR_PAUSE_LO+:3] : loc_pause;

  assign train_en      = trn_q[TC_EN];
  assign tmr_dis       = trn_q[TC_DIS_TMR];
  assign main_steps    = trn_q[TC_MAIN_LO+:4];
  assign prepost_steps = trn_q[TC_PP_LO+:4];

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (addr)
      OFF_UNP_LOW:  rdata_d = {16'h0000, unp_low_q};
      OFF_UNP_HIGH: rdata_d = unp_high_q;
      OFF_PBP_LOW:  rdata_d = {16'h0000, pbp_low_q};
      OFF_PBP_HIGH: rdata_d = pbp_high_q;
      OFF_PNP_LOW:  rdata_d = {16'h0000, pnp_low_q};
      OFF_PNP_HIGH: rdata_d = pnp_high_q;
      OFF_PADV:     rdata_d = adv_word;
      OFF_TRN_CTRL: rdata_d = trn_q;
      OFF_AN_CTRL:  rdata_d = an_ctrl_q;
      OFF_OVR:      rdata_d = ovr_q;
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd ? rdata_d : 32'h0000_0000;
    end
  end
  assign rdata = rdata_q;

  a_base_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !rx_base_acc |=> $stable(pbp_low_q) && $stable(pbp_high_q))
    else $error("base page changed without accept");
  a_base_cap: assert property (@(posedge mclk) disable iff (!nrst)
    rx_base_acc |=> pbp_low_q == $past(rx_page[15:0]))
    else $error("base page low not captured");
  a_next_cap: assert property (@(posedge mclk) disable iff (!nrst)
    rx_next_acc |=> pnp_high_q == $past(rx_page[47:16]))
    else $error("next page high not captured");
  a_prbs_src: assert property (@(posedge mclk) disable iff (!nrst)
    tx_np_page[PG_PRBS] == tx_prbs)
    else $error("bit 49 not from tx engine");
  a_np_high: assert property (@(posedge mclk) disable iff (!nrst)
    np_ctrl |-> tx_np_page[47:16] == unp_high_q)
    else $error("user high word not sent");
  a_np_flags: assert property (@(posedge mclk) disable iff (!nrst)
    np_ctrl |-> tx_np_page[15:11] == {tx_np, tx_ack, unp_low_q[13:11]})
    else $error("next page flags wrong");
  a_rd_data: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_TRN_CTRL |=> rdata[TC_EN] == train_en)
    else $error("training enable readback wrong");
  a_steps_range: assert property (@(posedge mclk) disable iff (!nrst)
    main_steps != 4'h0 && prepost_steps != 4'h0)
    else $error("step count zero");
  a_ovr_gate: assert property (@(posedge mclk) disable iff (!nrst)
    !an_ctrl_q[AN_OVR_EN] |-> adv_tech == loc_tech && adv_pause == loc_pause)
    else $error("override applied while disabled");
  a_adv_fields: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PADV |=> rdata[27] == $past(pbp_low_q[PG_RF]) && rdata[31] == 1'b0)
    else $error("advertised fault wrong");
  a_tmr_dis: assert property (@(posedge mclk) disable iff (!nrst)
    hit_trn |=> tmr_dis == $past(wdata[1]))
    else $error("timer disable not written");

  c_base_rx: cover property (@(posedge mclk) disable iff (!nrst) rx_base_acc ##1 rd);
  c_next_rx: cover property (@(posedge mclk) disable iff (!nrst) rx_next_acc && np_ctrl);
  c_ovr:     cover property (@(posedge mclk) disable iff (!nrst) hit_an ##1 ovr_on);
  c_clamp:   cover property (@(posedge mclk) disable iff (!nrst) hit_trn && main_wr != wdata[7:4]);
  c_padv_rd: cover property (@(posedge mclk) disable iff (!nrst) rd && addr == OFF_PADV);

  a_unp_low_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_unp_low |=>
    unp_low_q == ($past(wdata[15:0]) & NP_LOW_WMASK))
    else $error("user low word not written");

  a_unp_low_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !hit_unp_low |=>
    $stable(unp_low_q))
    else $error("user low word changed");

  a_unp_low_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_UNP_LOW |=>
    rdata == {16'h0000, $past(unp_low_q)})
    else $error("user low readback wrong");

  a_np_unused: assert property (@(posedge mclk) disable iff (!nrst)
    np_ctrl |->
    tx_np_page[PG_TOG-1:0] == 11'h000 && !tx_np_page[PG_PRBS-1])
    else $error("unused next page bits set");

  a_np_idle: assert property (@(posedge mclk) disable iff (!nrst)
    !np_ctrl |->
    tx_np_page[PG_PRBS-1:0] == 49'h0)
    else $error("user page sent without control");

  a_unp_high_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_unp_high |=>
    unp_high_q == $past(wdata))
    else $error("user high word not written");

  a_unp_high_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !hit_unp_high |=>
    $stable(unp_high_q))
    else $error("user high word changed");

  a_unp_high_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_UNP_HIGH |=>
    rdata == $past(unp_high_q))
    else $error("user high readback wrong");

  a_base_high_cap: assert property (@(posedge mclk) disable iff (!nrst)
    rx_base_acc |=>
    pbp_high_q == {2'b00, $past(rx_page[45:16])})
    else $error("base page high not captured");

  a_pbp_low_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PBP_LOW |=>
    rdata == {16'h0000, $past(pbp_low_q)})
    else $error("base page low readback wrong");

  a_pbp_high_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PBP_HIGH |=>
    rdata == $past(pbp_high_q))
    else $error("base page high readback wrong");

  a_next_low_cap: assert property (@(posedge mclk) disable iff (!nrst)
    rx_next_acc |=>
    pnp_low_q == {$past(rx_page[15:11]), 11'h000})
    else $error("next page low not captured");

  a_next_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !rx_next_acc |=>
    $stable(pnp_low_q) && $stable(pnp_high_q))
    else $error("next page changed without accept");

  a_pnp_low_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PNP_LOW |=>
    rdata == {16'h0000, $past(pnp_low_q)})
    else $error("next page low readback wrong");

  a_pnp_high_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PNP_HIGH |=>
    rdata == $past(pnp_high_q))
    else $error("next page high readback wrong");

  a_fec_cap: assert property (@(posedge mclk) disable iff (!nrst)
    rx_base_acc |=>
    fec_q == $past(rx_page[47:46]))
    else $error("partner FEC not captured");

  a_fec_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !rx_base_acc |=>
    $stable(fec_q))
    else $error("partner FEC changed without accept");

  a_adv_tech_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PADV |=>
    rdata[24:0] == $past(pbp_high_q[29:5]))
    else $error("advertised technology wrong");

  a_adv_fec_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PADV |=>
    rdata[26:25] == $past(fec_q))
    else $error("advertised FEC wrong");

  a_adv_pause_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_PADV |=>
    rdata[30:28] == {1'b0, $past(pbp_low_q[11:10])})
    else $error("advertised pause wrong");

  a_trn_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !hit_trn |=>
    $stable(trn_q))
    else $error("training control changed");

  a_trn_rd: assert property (@(posedge mclk) disable iff (!nrst)
    rd && addr == OFF_TRN_CTRL |=>
    rdata == $past(trn_q))
    else $error("training control readback wrong");

  a_train_en_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_trn |=>
    train_en == $past(wdata[TC_EN]))
    else $error("training enable not written");

  a_main_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_trn && wdata[TC_MAIN_LO+:4] != 4'h0 |=>
    main_steps == $past(wdata[TC_MAIN_LO+:4]))
    else $error("main step count not written");

  a_main_clamp: assert property (@(posedge mclk) disable iff (!nrst)
    hit_trn && wdata[TC_MAIN_LO+:4] == 4'h0 |=>
    main_steps == STEP_MIN)
    else $error("main step count not clamped");

  a_pp_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_trn && wdata[TC_PP_LO+:4] != 4'h0 |=>
    prepost_steps == $past(wdata[TC_PP_LO+:4]))
    else $error("pre/post step count not written");

  a_pp_clamp: assert property (@(posedge mclk) disable iff (!nrst)
    hit_trn && wdata[TC_PP_LO+:4] == 4'h0 |=>
    prepost_steps == STEP_MIN)
    else $error("pre/post step count not clamped");

  a_ovr_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_ovr |=>
    ovr_q == ($past(wdata) & OVR_WMASK))
    else $error("override fields not written");

  a_ovr_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !hit_ovr |=>
    $stable(ovr_q))
    else $error("override fields changed");

  a_ovr_apply: assert property (@(posedge mclk) disable iff (!nrst)
    an_ctrl_q[AN_OVR_EN] |->
    adv_tech == ovr_q[OVR_TECH_LO+:6] && adv_fec == ovr_q[OVR_FEC_LO+:2])
    else $error("override not applied");

  a_ovr_pause: assert property (@(posedge mclk) disable iff (!nrst)
    an_ctrl_q[AN_OVR_EN] |->
    adv_pause == ovr_q[OVR_PAUSE_LO+:3])
    else $error("pause override not applied");

  a_ovr_fec_off: assert property (@(posedge mclk) disable iff (!nrst)
    !an_ctrl_q[AN_OVR_EN] |->
    adv_fec == loc_fec)
    else $error("FEC override applied while disabled");

  a_an_wr: assert property (@(posedge mclk) disable iff (!nrst)
    hit_an |=>
    an_ctrl_q == $past(wdata))
    else $error("negotiation control not written");
endmodule

// ---- shared/kranpt_pkg.sv ----
// Package for the auto-negotiation page and training control register block
package kranpt_pkg;
  localparam int          ADDR_W            = 11;
  localparam logic [10:0] OFF_UNP_LOW       = 11'h4C5;
  localparam logic [10:0] OFF_UNP_HIGH      = 11'h4C6;
  localparam logic [10:0] OFF_PBP_LOW       = 11'h4C7;
  localparam logic [10:0] OFF_PBP_HIGH      = 11'h4C8;
  localparam logic [10:0] OFF_PNP_LOW       = 11'h4C9;
  localparam logic [10:0] OFF_PNP_HIGH      = 11'h4CA;
  localparam logic [10:0] OFF_PADV          = 11'h4CB;
  localparam logic [10:0] OFF_TRN_CTRL      = 11'h4D0;
  localparam logic [10:0] OFF_AN_CTRL       = 11'h4C0;
  localparam logic [10:0] OFF_OVR           = 11'h4C3;
  // Page bit positions (50-bit page, bit 49 made by the tx engine)
  localparam int          PG_NP             = 15;
  localparam int          PG_ACK            = 14;
  localparam int          PG_RF             = 13;
  localparam int          PG_MP             = 13;
  localparam int          PG_ACK2           = 12;
  localparam int          PG_TOG            = 11;
  localparam int          PG_PAUSE_LO       = 10;
  localparam int          PG_TECH_LO        = 21;
  localparam int          PG_FEC_LO         = 46;
  localparam int          PG_HI_LO          = 16;
  localparam int          PG_PRBS           = 49;
  localparam int          PG_W              = 50;
  // Field positions in training control
  localparam int          TC_EN             = 0;
  localparam int          TC_DIS_TMR        = 1;
  localparam int          TC_MAIN_LO        = 4;
  localparam int          TC_PP_LO          = 8;
  localparam logic [31:0] TC_RESET          = 32'h0000_0111;
  localparam logic [31:0] TC_WMASK          = 32'h0000_0FF3;
  localparam logic [15:0] NP_LOW_WMASK      = 16'h3800;
  localparam int          AN_OVR_EN         = 5;
  localparam logic [31:0] OVR_WMASK         = 32'h733F_0000;
  localparam int          OVR_TECH_LO       = 16;
  localparam int          OVR_FEC_LO        = 24;
  localparam int          OVR_PAUSE_LO      = 28;
  // Advertised-ability register fields
  localparam int          ADV_FEC_LO        = 25;
  localparam int          ADV_RF            = 27;
  localparam int          ADV_PAUSE_LO      = 28;
  localparam logic [3:0]  STEP_MIN          = 4'h1;
endpackage

// ---- testbench/kranpt_peer.sv ----
// Remote link partner model: delivers received pages to the block
`timescale 1ns/100ps
module kranpt_peer (
  input  wire logic        mclk,        // Register clock
  input  wire logic        nrst,        // Async reset, active low
  input  wire logic        go,          // Deliver one page
  input  wire logic        nxt,         // Page is a next page
  input  wire logic [49:0] pg,          // Page to deliver
  output logic      [49:0] rx_page,     // Page toward block
  output logic             rx_base_acc, // Base page accepted
  output logic             rx_next_acc  // Next page accepted
);
  // Page lines keep moving between accepts so a stray capture shows
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_page     <= 50'h0;
      rx_base_acc <= 1'b0;
      rx_next_acc <= 1'b0;
    end else begin
      rx_base_acc <= go & ~nxt;
      rx_next_acc <= go & nxt;
      rx_page     <= go ? pg : ~rx_page;
    end
  end
endmodule

// ---- testbench/tb_kranpt_regs.sv ----
// Self-checking bench for the page and training register block
`timescale 1ns/100ps
module tb_kranpt_regs import kranpt_pkg::*; ;
  logic        mclk = 0, nrst = 0, wr = 0, rd = 0, go = 0, nxt = 0;
  logic        np_ctrl = 0, tx_np = 0, tx_ack = 0, tx_prbs = 0;
  logic [10:0] addr = 0;
  logic [31:0] wdata = 0, rdata, seed = 32'hE5B5, w, e, h;
  logic [49:0] pg = 0, tx_np_page, rx_page, p;
  logic [63:0] t;
  logic        rx_base_acc, rx_next_acc, train_en, tmr_dis;
  logic [5:0]  loc_tech = 0, adv_tech;
  logic [1:0]  loc_fec = 0, adv_fec;
  logic [2:0]  loc_pause = 0, adv_pause;
  logic [3:0]  main_steps, prepost_steps;
  int          miscompares = 0, checked = 0, cyc = 0;
  always #5 mclk = ~mclk;
  kranpt_regs i_kranpt_regs (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .np_ctrl(np_ctrl), .tx_np(tx_np), .tx_ack(tx_ack),
    .tx_prbs(tx_prbs), .tx_np_page(tx_np_page), .rx_page(rx_page),
    .rx_base_acc(rx_base_acc), .rx_next_acc(rx_next_acc), .loc_tech(loc_tech),
    .loc_fec(loc_fec), .loc_pause(loc_pause), .adv_tech(adv_tech), .adv_fec(adv_fec),
    .adv_pause(adv_pause), .train_en(train_en), .tmr_dis(tmr_dis),
    .main_steps(main_steps), .prepost_steps(prepost_steps));
  kranpt_peer i_kranpt_peer (.mclk(mclk), .nrst(nrst), .go(go), .nxt(nxt), .pg(pg),
    .rx_page(rx_page), .rx_base_acc(rx_base_acc), .rx_next_acc(rx_next_acc));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Zero step counts read back as one
  function automatic logic [31:0] tcx(logic [31:0] v);
    logic [31:0] r;
    r = v & TC_WMASK;
    if (r[7:4] == 4'h0) r[7:4] = STEP_MIN;
    if (r[11:8] == 4'h0) r[11:8] = STEP_MIN;
    return r;
  endfunction
  task chk(input logic [63:0] g, input logic [63:0] x);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, g, x);
    end
  endtask
  task wrr(input logic [10:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task rdr(input logic [10:0] a);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
  endtask
  task snd(input logic n, input logic [49:0] v);
    @(posedge mclk);
    go <= 1'b1; nxt <= n; pg <= v;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk({train_en, tmr_dis}, 2'b10);
    chk({main_steps, prepost_steps}, 8'h11);
    rdr(OFF_TRN_CTRL);
    chk(rdata, TC_RESET);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : rnd();
      e = tcx(w);
      wrr(OFF_TRN_CTRL, w);
      chk({train_en, tmr_dis}, {e[0], e[1]});
      chk({main_steps, prepost_steps}, {e[7:4], e[11:8]});
      rdr(OFF_TRN_CTRL);
      chk(rdata, e);
    end
    $display("training test done");
    for (int i = 0; i < 6; i++) begin
      w = rnd();
      h = rnd();
      e = rnd();
      wrr(OFF_UNP_LOW, w);
      wrr(OFF_UNP_HIGH, h);
      rdr(OFF_UNP_LOW);
      chk(rdata, w & {16'h0, NP_LOW_WMASK});
      rdr(OFF_UNP_HIGH);
      chk(rdata, h);
      @(posedge mclk);
      np_ctrl <= i[0];
      tx_np <= e[1];
      tx_ack <= e[2];
      tx_prbs <= e[3];
      @(posedge mclk);
      #1;
      p = i[0] ? {e[3], 1'b0, h, e[1], e[2], w[13:11], 11'h0} : {e[3], 49'h0};
      chk(tx_np_page, p);
    end
    $display("next page test done");
    for (int i = 0; i < 6; i++) begin
      t = {rnd(), rnd()};
      p = t[49:0];
      snd(1'b0, p);
      rdr(OFF_PBP_LOW);
      chk(rdata, {16'h0, p[15:0]});
      rdr(OFF_PBP_HIGH);
      chk(rdata, {2'b00, p[45:16]});
      wrr(OFF_PBP_HIGH, 32'hFFFF_FFFF);
      e = {2'b00, p[11:10], p[13], p[47:46], p[45:21]};
      rdr(OFF_PADV);
      chk(rdata, e);
      t = {rnd(), rnd()};
      snd(1'b1, t[49:0]);
      rdr(OFF_PNP_LOW);
      chk(rdata, {16'h0, t[15:11], 11'h0});
      rdr(OFF_PNP_HIGH);
      chk(rdata, t[47:16]);
      rdr(OFF_PBP_HIGH);
      chk(rdata, {2'b00, p[45:16]});
    end
    rdr(11'h7FF);
    chk(rdata, 32'h0);
    $display("partner page test done");
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      e = rnd();
      @(posedge mclk);
      loc_tech <= e[5:0];
      loc_fec <= e[7:6];
      loc_pause <= e[10:8];
      wrr(OFF_OVR, w);
      wrr(OFF_AN_CTRL, 32'h20);
      rdr(OFF_OVR);
      chk(rdata, w & OVR_WMASK);
      chk({adv_tech, adv_fec, adv_pause}, {w[21:16], w[25:24], w[30:28]});
      wrr(OFF_AN_CTRL, e & 32'hFFFF_FFDF);
      rdr(OFF_AN_CTRL);
      chk(rdata, e & 32'hFFFF_FFDF);
      chk({adv_tech, adv_fec, adv_pause}, {e[5:0], e[7:6], e[10:8]});
    end
    $display("override test done");
    // Reset in mid-run must bring back the control defaults and clear captures
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk({train_en, tmr_dis}, 2'b10);
    chk({main_steps, prepost_steps}, 8'h11);
    rdr(OFF_PNP_HIGH);
    chk(rdata, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule
